// >>> core/rucb_pkg.sv
// package: register offsets, field positions and timing for the regulator config bank
package rucb_pkg;
  localparam logic [7:0] vendor_options_addr = 8'hd0;
  localparam logic [7:0] user_options_addr = 8'hd1;
  // user options word fields
  localparam int min_duty_hi = 15;
  localparam int min_duty_lo = 14;
  localparam int min_duty_en_bit = 13;
  localparam int hiz_ramp_down_bit = 12;
  localparam int sync_timeout_bit = 11;
  localparam int no_feed_fwd_bit = 9;
  localparam int act_on_faults_bit = 8;
  localparam int ext_sync_bit = 6;
  localparam int sync_out_bit = 5;
  localparam int lowside_on_bit = 2;
  localparam logic [15:0] user_defined_mask = 16'hfb64;
  // vendor options word fields (low byte)
  localparam int sense_ctl_hi = 5;
  localparam int sense_ctl_lo = 4;
  localparam int nonlinear_response_bit = 3;
  localparam int alt_ramp_bit = 2;
  localparam int power_good_pin_bit = 1;
  localparam int sync_push_pull_bit = 0;
  localparam logic [15:0] vendor_defined_mask = 16'h003f;
  localparam logic [15:0] user_reset = 16'h0000;
  localparam logic [15:0] vendor_reset = 16'h0000;
  localparam logic [1:0] sense_gnd_down = 2'h0;
  localparam logic [1:0] sense_vout_down = 2'h1;
  localparam logic [1:0] sense_vout_up = 2'h2;
  // timing
  localparam int clk_hz = 25000000;
  localparam int sync_timeout_ms = 500;
  localparam longint sync_timeout_cycles = longint'(clk_hz) * sync_timeout_ms / 1000;
  localparam int duty_steps = 256;
endpackage

// >>> core/rucb_config_bank.sv
// regulator user and vendor configuration bank with ramp, sync and fault logic
// Notes on behaviour
// - bits 15:14 give minimum on-time of 1 to 4 of 256 switching period parts
// - bit 13 enables minimum duty limit during ramps; zero means no minimum
// - bit 12 zero follows fall ramp time; one makes output high-z until undervoltage
// - bit 11 one stops sync output 500 ms after disable; zero keeps it running
// - bit 9 zero corrects loop coefficients for input voltage; one disables correction
// - bit 8 zero ignores received faults, or sequences down outward when sequencing
// - bit 8 one shuts down immediately on any fault from selected group
// - bit 6 zero clocks from the internal oscillator and ignores sync pin; one switches on external sync
// - bit 5 zero keeps sync input only; one drives internal clock out on sync while bit 6 is zero
// - bit 2 sets low-side drive off or on while device is disabled
// - sense control code 10 selects output-referenced up-slope sensing
// - minimum duty floor applies only while ramping, equal to code plus one over 256
// - sense control bits 5:4, code 00 ground down-slope, 01 output down-slope
`timescale 1ns/10ps
module rucb_config_bank #(
  parameter int period_w = 16,
  parameter longint sync_timeout = rucb_pkg::sync_timeout_cycles
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic wr_en,
  input wire logic rd_en,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] wr_data,
  input wire logic dev_enabled,
  input wire logic ramping,
  input wire logic [period_w-1:0] sw_period,
  input wire logic out_above_uv,
  input wire logic fault_rx,
  input wire logic sequencing_en,
  input wire logic int_osc_clk,
  input wire logic sync_in,
  output logic [15:0] rd_data,
  output logic rd_valid,
  output logic rd_ack_err,
  output logic [period_w-1:0] min_on_time,
  output logic min_on_active,
  output logic stage_hiz,
  output logic follow_fall_ramp,
  output logic feed_fwd_on,
  output logic fault_shutdown,
  output logic fault_seq_down,
  output logic use_ext_sync,
  output logic switch_clk,
  output logic sync_out,
  output logic sync_oe_n,
  output logic lowside_on,
  output logic [1:0] sense_mode,
  output logic sense_vout_ref,
  output logic sense_up_slope,
  output logic nonlinear_response_always,
  output logic alt_ramp_en,
  output logic power_good_pin_push_pull,
  output logic sync_push_pull
);
  logic [15:0] user_options_word;
  logic [15:0] vendor_options_word;
  logic [31:0] tmo_cnt;
  logic sync_stopped;
  logic [period_w+2:0] floor_prod;

  function automatic logic [15:0] masked(input logic [15:0] d, input logic [15:0] m);
    return d & m;
  endfunction

  // register writes
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      user_options_word <= rucb_pkg::user_reset;
      vendor_options_word <= rucb_pkg::vendor_reset;
    end else if (clk_en && wr_en) begin
      if (cmd_code == rucb_pkg::user_options_addr)
        user_options_word <= masked(wr_data, rucb_pkg::user_defined_mask);
      if (cmd_code == rucb_pkg::vendor_options_addr)
        vendor_options_word <= masked(wr_data, rucb_pkg::vendor_defined_mask);
    end
  end

  // register reads
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      rd_data <= 16'h0000;
      rd_valid <= 1'b0;
      rd_ack_err <= 1'b0;
    end else if (clk_en) begin
      rd_valid <= 1'b0;
      rd_ack_err <= 1'b0;
      if (rd_en) begin
        case (cmd_code)
          rucb_pkg::user_options_addr: begin
            rd_data <= user_options_word;
            rd_valid <= 1'b1;
          end
          rucb_pkg::vendor_options_addr: begin
            rd_data <= vendor_options_word;
            rd_valid <= 1'b1;
          end
          default: begin
            rd_data <= 16'h0000;
            rd_ack_err <= 1'b1;
          end
        endcase
      end
    end
  end

  assign floor_prod = (period_w+3)'(sw_period) *
    (period_w+3)'({1'b0, user_options_word[rucb_pkg::min_duty_hi:rucb_pkg::min_duty_lo]} + 3'h1);

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      min_on_time <= '0;
      min_on_active <= 1'b0;
    end else if (clk_en) begin
      min_on_time <= period_w'(floor_prod / rucb_pkg::duty_steps);
      min_on_active <= user_options_word[rucb_pkg::min_duty_en_bit] & ramping;
    end
  end

  // ramp-down, feed-forward, faults, low-side
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      stage_hiz <= 1'b0;
      follow_fall_ramp <= 1'b0;
      feed_fwd_on <= 1'b1;
      fault_shutdown <= 1'b0;
      fault_seq_down <= 1'b0;
      lowside_on <= 1'b0;
    end else if (clk_en) begin
      stage_hiz <= ramping && !dev_enabled && out_above_uv &&
                   user_options_word[rucb_pkg::hiz_ramp_down_bit];
      follow_fall_ramp <= ramping && !dev_enabled &&
                          !user_options_word[rucb_pkg::hiz_ramp_down_bit];
      feed_fwd_on <= !user_options_word[rucb_pkg::no_feed_fwd_bit];
      fault_shutdown <= fault_rx && user_options_word[rucb_pkg::act_on_faults_bit];
      fault_seq_down <= fault_rx && sequencing_en &&
                        !user_options_word[rucb_pkg::act_on_faults_bit];
      lowside_on <= !dev_enabled && user_options_word[rucb_pkg::lowside_on_bit];
    end
  end

  always_ff @(posedge clk_sys) begin
    if (rst) begin
      tmo_cnt <= 32'h0;
      sync_stopped <= 1'b0;
    end else if (clk_en) begin
      if (dev_enabled || !user_options_word[rucb_pkg::sync_timeout_bit]) begin
        tmo_cnt <= 32'h0;
        sync_stopped <= 1'b0;
      end else if (tmo_cnt >= 32'(sync_timeout - 1)) begin
        sync_stopped <= 1'b1;
      end else begin
        tmo_cnt <= tmo_cnt + 32'h1;
      end
    end
  end

  // sync pin and clock source
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      use_ext_sync <= 1'b0;
      switch_clk <= 1'b0;
      sync_out <= 1'b1;
      sync_oe_n <= 1'b1;
    end else if (clk_en) begin
      use_ext_sync <= user_options_word[rucb_pkg::ext_sync_bit];
      switch_clk <= user_options_word[rucb_pkg::ext_sync_bit] ? sync_in : int_osc_clk;
      if (user_options_word[rucb_pkg::sync_out_bit] && !user_options_word[rucb_pkg::ext_sync_bit]
          && !sync_stopped) begin
        sync_out <= int_osc_clk;
        sync_oe_n <= vendor_options_word[rucb_pkg::sync_push_pull_bit] ? 1'b0 : int_osc_clk;
      end else begin
        sync_out <= 1'b1;
        sync_oe_n <= 1'b1;
      end
    end
  end

  // vendor word decode
  always_ff @(posedge clk_sys) begin
    if (rst) begin
      sense_mode <= rucb_pkg::sense_gnd_down;
      sense_vout_ref <= 1'b0;
      sense_up_slope <= 1'b0;
      nonlinear_response_always <= 1'b0;
      alt_ramp_en <= 1'b0;
      power_good_pin_push_pull <= 1'b0;
      sync_push_pull <= 1'b0;
    end else if (clk_en) begin
      sense_mode <= vendor_options_word[rucb_pkg::sense_ctl_hi:rucb_pkg::sense_ctl_lo];
      case (vendor_options_word[rucb_pkg::sense_ctl_hi:rucb_pkg::sense_ctl_lo])
        rucb_pkg::sense_gnd_down: begin
          sense_vout_ref <= 1'b0;
          sense_up_slope <= 1'b0;
        end
        rucb_pkg::sense_vout_down: begin
          sense_vout_ref <= 1'b1;
          sense_up_slope <= 1'b0;
        end
        rucb_pkg::sense_vout_up: begin
          sense_vout_ref <= 1'b1;
          sense_up_slope <= 1'b1;
        end
        default: begin
          sense_vout_ref <= 1'b0;
          sense_up_slope <= 1'b0;
        end
      endcase
      nonlinear_response_always <= vendor_options_word[rucb_pkg::nonlinear_response_bit];
      alt_ramp_en <= vendor_options_word[rucb_pkg::alt_ramp_bit];
      power_good_pin_push_pull <= vendor_options_word[rucb_pkg::power_good_pin_bit];
      sync_push_pull <= vendor_options_word[rucb_pkg::sync_push_pull_bit];
    end
  end
endmodule

// >>> verif/rucb_chk_sva.sv
// checker: port assertions for the config bank
`timescale 1ns/10ps
module rucb_chk (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic clk_en,
  input wire logic rd_en,
  input wire logic [7:0] cmd_code,
  input wire logic [15:0] rd_data,
  input wire logic rd_valid,
  input wire logic ramping,
  input wire logic dev_enabled,
  input wire logic fault_rx,
  input wire logic sequencing_en,
  input wire logic min_on_active,
  input wire logic stage_hiz,
  input wire logic lowside_on,
  input wire logic fault_shutdown,
  input wire logic fault_seq_down,
  input wire logic use_ext_sync,
  input wire logic sync_oe_n,
  input wire logic [1:0] sense_mode,
  input wire logic sense_vout_ref,
  input wire logic sense_up_slope
);
  default clocking @(posedge clk_sys);
  endclocking
  default disable iff (rst);
  sequence s_rd_user;
    rd_en && clk_en && cmd_code == rucb_pkg::user_options_addr;
  endsequence
  a_user_mask: assert property (s_rd_user |=> rd_valid &&
    (rd_data & ~rucb_pkg::user_defined_mask) == 16'h0000) else $error("undefined bits read");
  a_min_on_ramp: assert property (min_on_active |-> $past(ramping))
    else $error("min duty outside ramp");
  a_hiz_disabled: assert property (stage_hiz |-> $past(ramping && !dev_enabled))
    else $error("high-z while enabled");
  a_lowside_dis: assert property (lowside_on |-> $past(!dev_enabled))
    else $error("low-side on while enabled");
  a_fault_stop: assert property (fault_shutdown |-> $past(fault_rx))
    else $error("shutdown without fault");
  a_seq_down: assert property (fault_seq_down |-> $past(fault_rx && sequencing_en)
    && !fault_shutdown) else $error("bad sequence down");
  a_ext_nodrive: assert property (use_ext_sync |-> sync_oe_n)
    else $error("sync driven with external clock");
  a_sense_decode: assert property (sense_up_slope == (sense_mode == 2'h2) &&
    sense_vout_ref == (sense_mode inside {2'h1, 2'h2})) else $error("sense decode wrong");
endmodule
bind rucb_config_bank rucb_chk chk (.clk_sys(clk_sys), .rst(rst), .clk_en(clk_en),
  .rd_en(rd_en), .cmd_code(cmd_code), .rd_data(rd_data), .rd_valid(rd_valid),
  .ramping(ramping), .dev_enabled(dev_enabled), .fault_rx(fault_rx),
  .sequencing_en(sequencing_en), .min_on_active(min_on_active), .stage_hiz(stage_hiz),
  .lowside_on(lowside_on), .fault_shutdown(fault_shutdown), .fault_seq_down(fault_seq_down),
  .use_ext_sync(use_ext_sync), .sync_oe_n(sync_oe_n), .sense_mode(sense_mode),
  .sense_vout_ref(sense_vout_ref), .sense_up_slope(sense_up_slope));

// >>> verif/rucb_host.sv
// host model: issues word writes and reads to the config bank
`timescale 1ns/10ps
module rucb_host (
  input wire logic clk_sys,
  output logic wr_en = 1'b0,
  output logic rd_en = 1'b0,
  output logic [7:0] cmd_code = 8'h00,
  output logic [15:0] wr_data = 16'h0000
);
  task automatic xfer(input logic wr, input logic [7:0] cmd, input logic [15:0] data);
    @(posedge clk_sys);
    wr_en <= wr;
    rd_en <= !wr;
    cmd_code <= cmd;
    wr_data <= data;
    @(posedge clk_sys);
    wr_en <= 1'b0;
    rd_en <= 1'b0;
    // released lines show inverted values
    cmd_code <= ~cmd;
    wr_data <= ~data;
  endtask
endmodule

// >>> verif/tb_top.sv
// testbench: register traffic, derived outputs and sync time-out
`timescale 1ns/10ps
module tb_top;
  logic clk_sys = 1'b0, rst = 1'b1, dev_enabled = 1'b1, ramping = 1'b0, out_above_uv = 1'b0;
  logic fault_rx = 1'b0, sequencing_en = 1'b0, int_osc_clk = 1'b0, sync_in = 1'b0;
  logic wr_en, rd_en, rd_valid, rd_ack_err, min_on_active, stage_hiz, follow_fall_ramp;
  logic feed_fwd_on, fault_shutdown, fault_seq_down, use_ext_sync, switch_clk, sync_out;
  logic sync_oe_n, lowside_on, sense_vout_ref, sense_up_slope, nonlin_all, alt_ramp;
  logic power_good_pp, sync_pp, clk_en = 1'b1, pp = 1'b1;
  logic [7:0] cmd_code;
  logic [15:0] sw_period = 16'h0000, wr_data, rd_data, min_on_time, w, v, m;
  logic [1:0] sense_mode, osc_q;
  logic [16:0] expq[$];
  int mismatches = 0, checks = 0, seed = 80344;
  always #20 clk_sys = ~clk_sys;
  rucb_host host (.clk_sys(clk_sys), .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code),
    .wr_data(wr_data));
  rucb_config_bank #(.period_w(16), .sync_timeout(20)) uut (.clk_sys(clk_sys), .rst(rst),
    .clk_en(clk_en), .wr_en(wr_en), .rd_en(rd_en), .cmd_code(cmd_code), .wr_data(wr_data),
    .dev_enabled(dev_enabled), .ramping(ramping), .sw_period(sw_period),
    .out_above_uv(out_above_uv), .fault_rx(fault_rx), .sequencing_en(sequencing_en),
    .int_osc_clk(int_osc_clk), .sync_in(sync_in), .rd_data(rd_data), .rd_valid(rd_valid),
    .rd_ack_err(rd_ack_err), .min_on_time(min_on_time), .min_on_active(min_on_active),
    .stage_hiz(stage_hiz), .follow_fall_ramp(follow_fall_ramp), .feed_fwd_on(feed_fwd_on),
    .fault_shutdown(fault_shutdown), .fault_seq_down(fault_seq_down),
    .use_ext_sync(use_ext_sync), .switch_clk(switch_clk), .sync_out(sync_out),
    .sync_oe_n(sync_oe_n), .lowside_on(lowside_on), .sense_mode(sense_mode),
    .sense_vout_ref(sense_vout_ref), .sense_up_slope(sense_up_slope),
    .nonlinear_response_always(nonlin_all), .alt_ramp_en(alt_ramp),
    .power_good_pin_push_pull(power_good_pp), .sync_push_pull(sync_pp));
  task automatic check(input logic [16:0] got, input logic [16:0] exp);
    checks++;
    if (got !== exp) begin
      mismatches++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", checks, mismatches);
    if (mismatches == 0 && checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  task automatic rd(input logic [7:0] cmd, input logic [16:0] exp);
    expq.push_back(exp);
    host.xfer(1'b0, cmd, 16'h0000);
  endtask
  task automatic sync_case(input logic [15:0] word, input int n, input logic idle);
    dev_enabled <= 1'b1;
    host.xfer(1'b1, rucb_pkg::user_options_addr, word);
    dev_enabled <= 1'b0;
    repeat (n) @(posedge clk_sys);
    // driving: push-pull enables always, open-drain only while the clock is low
    #1 check({sync_oe_n, sync_out}, idle ? 2'h3 : {osc_q[1] & !pp, osc_q[1]});
    @(posedge clk_sys);
  endtask
  always @(posedge clk_sys) begin
    {int_osc_clk, sync_in} <= 2'($random(seed));
    osc_q <= {int_osc_clk, sync_in};
    if (rd_valid === 1'b1 || rd_ack_err === 1'b1) begin
      if (expq.size() == 0)
        check({rd_ack_err, rd_data}, 17'h1ffff);
      else
        check({rd_ack_err, rd_data}, expq.pop_front());
    end
  end
  initial begin
    repeat (4000) @(posedge clk_sys);
    mismatches++;
    results();
  end
  initial begin
    repeat (3) @(posedge clk_sys);
    rst <= 1'b0;
    rd(rucb_pkg::user_options_addr, 17'h00000);
    #1 check({feed_fwd_on, sync_out, sync_oe_n}, 3'h7);
    rd(8'hd2, 17'h10000);
    host.xfer(1'b1, rucb_pkg::user_options_addr, 16'hffff);
    rd(rucb_pkg::user_options_addr, 17'h0fb64);
    host.xfer(1'b1, rucb_pkg::vendor_options_addr, 16'hffff);
    rd(rucb_pkg::vendor_options_addr, 17'h0003f);
    // a write while clk_en is low must not land
    @(posedge clk_sys);
    clk_en <= 1'b0;
    host.xfer(1'b1, rucb_pkg::user_options_addr, 16'h0000);
    clk_en <= 1'b1;
    rd(rucb_pkg::user_options_addr, 17'h0fb64);
    for (int i = 0; i < 12; i++) begin
      w = 16'($random(seed));
      v = 16'($random(seed));
      {dev_enabled, ramping, fault_rx, sequencing_en, out_above_uv} <= 5'(w ^ v);
      sw_period <= v ^ 16'hc3a5;
      host.xfer(1'b1, rucb_pkg::user_options_addr, w);
      host.xfer(1'b1, rucb_pkg::vendor_options_addr, v);
      m = w & rucb_pkg::user_defined_mask;
      rd(rucb_pkg::user_options_addr, {1'b0, m});
      #1 check(min_on_active, m[13] & ramping);
      check(min_on_time, 17'((32'(sw_period) * (32'(m[15:14]) + 1)) >> 8));
      check({feed_fwd_on, use_ext_sync}, {!m[9], m[6]});
      check(lowside_on, !dev_enabled & m[2]);
      check(switch_clk, m[6] ? osc_q[0] : osc_q[1]);
      check({fault_shutdown, fault_seq_down},
        {fault_rx & m[8], fault_rx & sequencing_en & !m[8]});
      check({stage_hiz, follow_fall_ramp}, {ramping & !dev_enabled & out_above_uv & m[12],
        ramping & !dev_enabled & !m[12]});
      check({sense_mode, sense_vout_ref, sense_up_slope},
        {v[5:4], v[5:4] == 2'h1 || v[5:4] == 2'h2, v[5:4] == 2'h2});
      check({nonlin_all, alt_ramp, power_good_pp, sync_pp}, v[3:0]);
      @(posedge clk_sys);
    end
    ramping <= 1'b0;
    host.xfer(1'b1, rucb_pkg::vendor_options_addr, 16'h0001);
    sync_case(16'h0020, 30, 1'b0);
    sync_case(16'h0820, 10, 1'b0);
    sync_case(16'h0820, 30, 1'b1);
    sync_case(16'h0060, 5, 1'b1);
    sync_case(16'h0000, 5, 1'b1);
    host.xfer(1'b1, rucb_pkg::vendor_options_addr, 16'h0000);
    pp = 1'b0;
    sync_case(16'h0020, 5, 1'b0);
    if (expq.size() != 0)
      mismatches++;
    results();
  end
endmodule
